/* rtl/prc_pkg.sv */
// Constants for the power-unit regulator control register bank.
// Assumes a 32-bit APB master; register indices map to byte address 4*idx.
// Contract
// [RL1] Monitor bit 7 unmasks supply-level interrupt.
// [RL2] Monitor bit 6 shows supply interrupt raised.
// [RL3] Monitor bit 5 shows live comparator state.
// [RL4] Monitor bits 3:0 threshold; bit 4 reserved.
// [RL5] Thermal bit 7 unmask; bits 5:0 reserved.
// [RL6] Thermal bit 6 shows thermal interrupt raised.
// [RL7] Voltage code six bits, regulator four eight.
// [RL8] Control bit 7 switches regulator on.
// [RL9] Control bit 2 picks switching phase. Regulator four has no phase output; its bit 2 is reserved.
// [RL10] Control bit 1 lets faults raise interrupts. Regulator four has no fault input; its bit 1 is reserved.
// [RL11] Control bit 0 reads live power-good.
// [RL12] Unused control bits are reserved, read-only.
// [RL13] Software keeps reserved bits at defaults.
// [RL14] Read-only bits ignore writes, read status.
package prc_pkg;

    localparam int unsigned ADDR_W = 12;
    localparam int unsigned IDX_W  = 8;
    localparam int unsigned NREG   = 4;
    localparam int unsigned NEVT   = 5;

    // Register indices; the byte address is four times the index.
    localparam logic [IDX_W-1:0] IDX_MON   = 8'h00;
    localparam logic [IDX_W-1:0] IDX_THERM = 8'h01;
    localparam logic [IDX_W-1:0] IDX_VSEL [NREG] =
        '{8'h10, 8'h20, 8'h30, 8'h40};
    localparam logic [IDX_W-1:0] IDX_CTRL [NREG] =
        '{8'h12, 8'h22, 8'h32, 8'h41};
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 8'hd0;
    localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE = 8'hd1;
    localparam logic [IDX_W-1:0] IDX_IRQ_CLEAR  = 8'hd2;

    // Field positions.
    localparam int unsigned B_UNMASK   = 7;
    localparam int unsigned B_FLAG     = 6;
    localparam int unsigned B_LIVE     = 5;
    localparam int unsigned THR_W      = 4;
    localparam int unsigned B_ON       = 7;
    localparam int unsigned B_PHASE    = 2;
    localparam int unsigned B_FLTEN    = 1;
    localparam int unsigned B_PGOOD    = 0;
    localparam int unsigned VSEL_W     = 6;
    localparam int unsigned VSEL4_W    = 8;

    // Event bits of the interrupt status, enable and clear registers.
    localparam int unsigned EV_SUPPLY  = 0;
    localparam int unsigned EV_THERMAL = 1;
    localparam int unsigned EV_FAULT0  = 2;

    // Reset values.
    localparam logic [7:0] RST_MON   = 8'h00;
    localparam logic [7:0] RST_THERM = 8'h00;
    localparam logic [7:0] RST_VSEL [NREG] =
        '{8'h00, 8'h39, 8'h24, 8'h54};
    localparam logic [7:0] RST_CTRL [NREG] =
        '{8'h00, 8'h84, 8'h80, 8'h00};
    localparam logic [NEVT-1:0] RST_IRQ_EN = 5'h00;

endpackage : prc_pkg

/* rtl/prc_regs.sv */
// Register bank of the regulator control block, an APB slave.
// Assumes comparator, thermal, fault and power-good inputs come from
// analogue pins and are asynchronous to pclk.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/10ps
module prc_regs
    import prc_pkg::*;
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [ADDR_W-1:0]    paddr,
    input  wire logic [31:0]          pwdata,
    input  wire logic [3:0]           pstrb,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 supply_below_threshold_live,
    input  wire logic                 thermal_alarm,
    input  wire logic [NREG-2:0]      regulator_fault,
    input  wire logic [NREG-1:0]      regulator_power_good,
    output logic      [THR_W-1:0]     supply_detect_threshold,
    output logic      [NREG-1:0]      regulator_enable,
    output logic      [NREG-2:0]      regulator_phase,
    output logic      [VSEL_W-1:0]    output_voltage_code_one,
    output logic      [VSEL_W-1:0]    output_voltage_code_two,
    output logic      [VSEL_W-1:0]    output_voltage_code_three,
    output logic      [VSEL4_W-1:0]   output_voltage_code_four,
    output logic                      irq
);

    localparam int unsigned NSYNC = 2 + (NREG - 1) + NREG;

    logic [NSYNC-1:0]   pins_raw;
    logic [NSYNC-1:0]   pins_sync;
    logic               supply_low_s;
    logic               thermal_s;
    logic [NREG-2:0]    fault_s;
    logic [NREG-1:0]    pgood_s;
    logic               supply_low_d_r;
    logic               thermal_d_r;
    logic [NREG-2:0]    fault_d_r;

    logic               supply_level_irq_unmask_r;
    logic               thermal_irq_unmask_r;
    logic [THR_W-1:0]   threshold_r;
    logic [7:0]         vsel_r [NREG];
    logic [NREG-1:0]    on_r;
    logic [NREG-2:0]    phase_r;
    logic [NREG-2:0]    fault_irq_enable_r;
    logic [NEVT-1:0]    irq_en_r;
    logic [NEVT-1:0]    evt_set;
    logic [NEVT-1:0]    evt_clr;
    logic [NEVT-1:0]    evt_flags;

    logic [IDX_W-1:0]   idx;
    logic               in_range;
    logic               setup;
    logic               wr_en;
    logic               lane0;
    logic [7:0]         wbyte;
    logic [7:0]         rbyte_nxt;
    logic               hit_nxt;
    logic               wr_ro_hit;

    logic [31:0]        prdata_r;
    logic               pready_r;
    logic               pslverr_r;
    logic               irq_r;

    // Every analogue input passes two flops before anything reads it.
    assign pins_raw = {regulator_power_good, regulator_fault,
                       thermal_alarm, supply_below_threshold_live};

    prc_sync #(
        .WIDTH   (NSYNC)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .async_in(pins_raw),
        .sync_out(pins_sync)
    );

    assign supply_low_s = pins_sync[0];
    assign thermal_s    = pins_sync[1];
    assign fault_s      = pins_sync[2 +: (NREG - 1)];
    assign pgood_s      = pins_sync[2 + (NREG - 1) +: NREG];

    // Edge detectors run on the synchronised copies only.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            supply_low_d_r <= 1'b0;
            thermal_d_r    <= 1'b0;
            fault_d_r      <= '0;
        end else begin
            supply_low_d_r <= supply_low_s;
            thermal_d_r    <= thermal_s;
            fault_d_r      <= fault_s;
        end
    end

    // APB decode: the word index sits in paddr[9:2], upper bits must be 0.
    assign idx      = paddr[IDX_W+1:2];
    assign in_range = (paddr[ADDR_W-1:IDX_W+2] == '0);
    assign setup    = psel & ~penable;
    assign wr_en    = psel & penable & pwrite & pready_r & ~pslverr_r;
    assign lane0    = pstrb[0];
    assign wbyte    = pwdata[7:0];

    // Read mux and address hit; reserved bits read as zero.
    always_comb begin
        rbyte_nxt = 8'h00;
        hit_nxt   = 1'b0;
        wr_ro_hit = 1'b0;
        if (in_range) begin
            if (idx == IDX_MON) begin
                hit_nxt = 1'b1;
                rbyte_nxt[B_UNMASK]    = supply_level_irq_unmask_r; // [RL1]
                rbyte_nxt[B_FLAG]      = evt_flags[EV_SUPPLY];      // [RL2]
                rbyte_nxt[B_LIVE]      = supply_low_s;              // [RL3]
                rbyte_nxt[THR_W-1:0]   = threshold_r;               // [RL4]
            end else if (idx == IDX_THERM) begin
                hit_nxt = 1'b1;
                rbyte_nxt[B_UNMASK]    = thermal_irq_unmask_r;      // [RL5]
                rbyte_nxt[B_FLAG]      = evt_flags[EV_THERMAL];     // [RL6]
            end else if (idx == IDX_IRQ_STATUS) begin
                hit_nxt = 1'b1;
                rbyte_nxt[NEVT-1:0]    = evt_flags;
            end else if (idx == IDX_IRQ_ENABLE) begin
                hit_nxt = 1'b1;
                rbyte_nxt[NEVT-1:0]    = irq_en_r;
            end else if (idx == IDX_IRQ_CLEAR) begin
                // Write-only; reads return zero.
                hit_nxt = 1'b1;
            end
            for (int i = 0; i < NREG; i++) begin
                if (idx == IDX_VSEL[i]) begin
                    hit_nxt   = 1'b1;
                    rbyte_nxt = vsel_r[i];                          // [RL7]
                end
                if (idx == IDX_CTRL[i]) begin
                    hit_nxt = 1'b1;
                    rbyte_nxt[B_ON]    = on_r[i];                   // [RL8]
                    rbyte_nxt[B_PGOOD] = pgood_s[i];                // [RL11]
                    if (i < NREG - 1) begin
                        rbyte_nxt[B_PHASE] = phase_r[i];            // [RL9]
                        rbyte_nxt[B_FLTEN] = fault_irq_enable_r[i]; // [RL10]
                    end
                end
            end
        end
        wr_ro_hit = hit_nxt & (idx == IDX_IRQ_STATUS);
    end

    // The answer is prepared in the setup cycle, so pready is high in the
    // first access cycle: every transfer takes exactly two cycles.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else if (setup) begin
            pready_r  <= 1'b1;
            pslverr_r <= ~hit_nxt;
            prdata_r  <= (pwrite | ~hit_nxt) ? 32'h0000_0000
                                             : {24'h00_0000, rbyte_nxt};
        end else begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end
    end

    // Supply monitor and thermal control fields; the flag, live and
    // reserved bits have no storage and so ignore writes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            supply_level_irq_unmask_r <= RST_MON[B_UNMASK];
            threshold_r               <= RST_MON[THR_W-1:0];
            thermal_irq_unmask_r      <= RST_THERM[B_UNMASK];
        end else if (wr_en && lane0) begin
            if (idx == IDX_MON) begin
                supply_level_irq_unmask_r <= wbyte[B_UNMASK];       // [RL1]
                threshold_r               <= wbyte[THR_W-1:0];      // [RL4] [RL14]
            end
            if (idx == IDX_THERM) begin
                thermal_irq_unmask_r      <= wbyte[B_UNMASK];       // [RL5] [RL14]
            end
        end
    end

    // Per-regulator voltage code and control fields.
    genvar r;
    generate
        for (r = 0; r < NREG; r++) begin : g_reg
            localparam int unsigned VW = (r == NREG - 1) ? VSEL4_W : VSEL_W;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    vsel_r[r] <= RST_VSEL[r];
                    on_r[r]   <= RST_CTRL[r][B_ON];
                end else if (wr_en && lane0) begin
                    if (idx == IDX_VSEL[r]) begin
                        // Upper bits of short codes stay zero.
                        vsel_r[r] <= {{(8 - VW){1'b0}}, wbyte[VW-1:0]}; // [RL7] [RL14]
                    end
                    if (idx == IDX_CTRL[r]) begin
                        on_r[r] <= wbyte[B_ON];                     // [RL8]
                    end
                end
            end
            if (r < NREG - 1) begin : g_buck
                always_ff @(posedge pclk or negedge presetn) begin
                    if (!presetn) begin
                        phase_r[r]            <= RST_CTRL[r][B_PHASE];
                        fault_irq_enable_r[r] <= RST_CTRL[r][B_FLTEN];
                    end else if (wr_en && lane0 && idx == IDX_CTRL[r]) begin
                        phase_r[r]            <= wbyte[B_PHASE];    // [RL9]
                        fault_irq_enable_r[r] <= wbyte[B_FLTEN];    // [RL10] [RL12]
                    end
                end
            end
        end
    endgenerate

    // Interrupt enable register of the same layout as the status.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_r <= RST_IRQ_EN;
        end else if (wr_en && lane0 && idx == IDX_IRQ_ENABLE) begin
            irq_en_r <= wbyte[NEVT-1:0];
        end
    end

    // Events are raised only while their own mask lets them through; a
    // masked crossing is dropped, not held back for a later unmask.
    always_comb begin
        evt_set             = '0;
        evt_set[EV_SUPPLY]  = supply_low_s & ~supply_low_d_r
                              & supply_level_irq_unmask_r;          // [RL2]
        evt_set[EV_THERMAL] = thermal_s & ~thermal_d_r
                              & thermal_irq_unmask_r;               // [RL6]
        evt_set[EV_FAULT0 +: (NREG - 1)] = fault_s & ~fault_d_r
                              & fault_irq_enable_r;                 // [RL10]
    end

    // Write-one-to-clear; writes to the status register itself do nothing.
    assign evt_clr = (wr_en && lane0 && idx == IDX_IRQ_CLEAR && !wr_ro_hit)
                     ? wbyte[NEVT-1:0] : '0;                        // [RL14]

    prc_sticky #(
        .WIDTH    (NEVT)
    ) u_sticky (
        .pclk     (pclk),
        .presetn  (presetn),
        .set_pulse(evt_set),
        .clr_pulse(evt_clr),
        .flags    (evt_flags)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(evt_flags & irq_en_r);
        end
    end

    assign prdata                    = prdata_r;
    assign pready                    = pready_r;
    assign pslverr                   = pslverr_r;
    assign irq                       = irq_r;
    assign supply_detect_threshold   = threshold_r;
    assign regulator_enable          = on_r;
    assign regulator_phase           = phase_r;
    assign output_voltage_code_one   = vsel_r[0][VSEL_W-1:0];
    assign output_voltage_code_two   = vsel_r[1][VSEL_W-1:0];
    assign output_voltage_code_three = vsel_r[2][VSEL_W-1:0];
    assign output_voltage_code_four  = vsel_r[3];

endmodule // prc_regs

/* rtl/prc_sticky.sv */
// Sticky event flags with a per-bit clear.
// Assumes set and clear are one-cycle pulses on the same clock.
`timescale 1ns/10ps
module prc_sticky #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] set_pulse,
    input  wire logic [WIDTH-1:0] clr_pulse,
    output logic      [WIDTH-1:0] flags
);

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            // A set in the cycle of a clear wins so no event is lost.
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    flags[g] <= 1'b0;
                end else if (set_pulse[g]) begin
                    flags[g] <= 1'b1;
                end else if (clr_pulse[g]) begin
                    flags[g] <= 1'b0;
                end
            end
        end
    endgenerate

endmodule // prc_sticky

/* rtl/prc_sync.sv */
// Two-flop synchroniser for a vector of unrelated level inputs.
// Assumes each bit is an independent slow level from a pin.
`timescale 1ns/10ps
module prc_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            logic meta_r;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta_r      <= 1'b0;
                    sync_out[g] <= 1'b0;
                end else begin
                    meta_r      <= async_in[g];
                    sync_out[g] <= meta_r;
                end
            end
        end
    endgenerate

endmodule // prc_sync

/* verification/prc_host.sv */
// Host processor model: an APB master driving the register bank.
// Assumes callers enter xfer just after a rising edge of pclk.
`timescale 1ns/10ps
module prc_host (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    output logic [3:0]       pstrb,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        {psel, penable, pwrite} = 3'h0;
        paddr  = 12'h000;
        pwdata = 32'h0;
        pstrb  = 4'h0;
    end

    // An idle edge before each setup keeps one assignment per time step.
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d, output logic [31:0] rd,
                        output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= 4'hf;
        @(posedge pclk);
        penable <= 1'b1;
        // No cycle count is assumed; only the bench watchdog ends a wait.
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Released data shows no stale copy of the last word.
        pwdata  <= ~d;
    endtask
endmodule // prc_host

/* verification/prc_regs_properties.sv */
// Concurrent checks on the APB side and control outputs of prc_regs.
// Assumes it is bound to prc_regs and sees only that module's ports.
`timescale 1ns/10ps
module prc_regs_props
    import prc_pkg::*;
(
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [ADDR_W-1:0]  paddr,
    input wire logic [31:0]        pwdata,
    input wire logic [3:0]         pstrb,
    input wire logic [31:0]        prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    input wire logic [THR_W-1:0]   supply_detect_threshold,
    input wire logic [NREG-1:0]    regulator_enable,
    input wire logic [VSEL4_W-1:0] output_voltage_code_four,
    input wire logic               irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic       acc;
    logic       wr;
    logic       rd;
    logic [7:0] wd;
    assign acc = psel & penable & pready;
    assign wr  = acc & pwrite & pstrb[0];
    assign rd  = acc & ~pwrite;
    assign wd  = pwdata[7:0];

    AST_READY_NEXT: assert property (psel && !penable |=> pready)
        else $error("pready did not follow the setup cycle");
    AST_READY_ONE: assert property (pready |=> !pready)
        else $error("pready stood longer than one cycle");
    AST_ERR_UNMAPPED: assert property (acc && paddr == 12'h3fc |-> pslverr)
        else $error("unmapped access gave no slave error");
    AST_RD_UPPER: assert property (rd |-> prdata[31:8] == 24'h000000)
        else $error("read data above the low byte not zero");
    AST_MON_READ: assert property (rd && paddr == 12'h000 |->
        prdata[4] == 1'b0 && prdata[3:0] == supply_detect_threshold)
        else $error("monitor read disagrees with threshold output");
    AST_THERM_RSV: assert property (rd && paddr == 12'h004 |->
        prdata[5:0] == 6'h00) else $error("thermal reserved bits not zero");
    AST_THR_WRITE: assert property (wr && paddr == 12'h000 |=>
        supply_detect_threshold == $past(wd) % 16)
        else $error("threshold output missed a write");
    AST_THR_HOLD: assert property (!(wr && paddr == 12'h000) |=>
        $stable(supply_detect_threshold))
        else $error("threshold changed without a write");
    AST_V4_WRITE: assert property (wr && paddr == 12'h100 |=>
        output_voltage_code_four == $past(wd))
        else $error("regulator four code missed a write");
    AST_ON4_WRITE: assert property (wr && paddr == 12'h104 && wd[7]
        |=> regulator_enable[3]) else $error("regulator four not enabled");

    cover property (wr && paddr == 12'h104);
    cover property (acc && pslverr);
    cover property ($rose(irq));
endmodule // prc_regs_props

/* verification/testbench.sv */
// Self-checking bench for prc_regs with a host model on APB.
// Assumes prc_pkg, the design files, the host and the checker compiled.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module testbench;
    import prc_pkg::*;
    localparam logic [11:0] AD [10] = '{12'h000, 12'h004, 12'h040,
        12'h048, 12'h080, 12'h088, 12'h0c0, 12'h0c8, 12'h100, 12'h104};
    localparam logic [7:0] WM [10] = '{8'h8f, 8'h80, 8'h3f, 8'h86,
        8'h3f, 8'h86, 8'h3f, 8'h86, 8'hff, 8'h80};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [3:0]  pstrb, supply_detect_threshold, regulator_enable;
    logic [3:0]  regulator_power_good;
    logic [2:0]  regulator_fault, regulator_phase;
    logic [5:0]  output_voltage_code_one, output_voltage_code_two;
    logic [5:0]  output_voltage_code_three;
    logic [7:0]  output_voltage_code_four, d;
    logic        supply_below_threshold_live, thermal_alarm;
    logic [7:0]  sh [10];
    logic [1:0]  flag;
    logic [15:0] seed;
    logic [36:0] outs;
    int          n_fail, checked, k;

    assign outs = {regulator_enable, regulator_phase, supply_detect_threshold,
        output_voltage_code_one, output_voltage_code_two,
        output_voltage_code_three, output_voltage_code_four};
    prc_regs dut_u (.*);
    prc_host host_u (.*);

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    function automatic logic [15:0] lfsr(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [31:0] exp_rd(int r);
        logic [7:0] v;
        v = sh[r];
        if (r == 0) v[6:5] = {flag[0], supply_below_threshold_live};
        if (r == 1) v[6] = flag[1];
        if (r > 2 && r % 2 == 1) v[0] = regulator_power_good[(r - 3) / 2];
        return {24'h0, v};
    endfunction
    function automatic logic [36:0] exp_out();
        return {sh[9][7], sh[7][7], sh[5][7], sh[3][7], sh[7][2], sh[5][2],
            sh[3][2], sh[0][3:0], sh[2][5:0], sh[4][5:0], sh[6][5:0], sh[8]};
    endfunction

    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        host_u.xfer(1'b1, a, {24'h0, v}, rdv, err);
    endtask
    task automatic chk_rd(input int r);
        host_u.xfer(1'b0, AD[r], 32'h0, rdv, err);
        `CHK("register read", exp_rd(r), rdv)
    endtask
    task automatic wait_pins();
        repeat (6) @(posedge pclk);
    endtask
    task automatic rst();
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        sh[0] = RST_MON;
        sh[1] = RST_THERM;
        flag = 2'b00;
        for (int i = 0; i < 4; i++) begin
            sh[2 * i + 2] = RST_VSEL[i];
            sh[2 * i + 3] = RST_CTRL[i];
        end
        repeat (3) @(posedge pclk);
        for (int i = 0; i < 10; i++) chk_rd(i);
        `CHK("outputs", exp_out(), outs)
        $display("test reset done");
    endtask
    task automatic summarize();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        // The span is far above the few hundred cycles the tests need.
        repeat (20000) @(posedge pclk);
        n_fail++;
        summarize();
    end

    initial begin
        {presetn, supply_below_threshold_live, thermal_alarm} = 3'h0;
        {regulator_fault, regulator_power_good} = 7'h00;
        {n_fail, checked} = 0;
        seed = 16'd37574;
        @(posedge pclk);
        rst();
        regulator_power_good <= seed[3:0];
        wait_pins();
        for (int i = 0; i < 24; i++) begin
            seed = lfsr(seed);
            k = seed[15:8] % 10;
            d = seed[7:0] & WM[k];
            wr(AD[k], d);
            sh[k] = d;
            chk_rd(k);
        end
        `CHK("outputs", exp_out(), outs)
        for (int j = 0; j < 3; j++) begin
            k = (j == 2) ? 9 : j;
            wr(AD[k], 8'hff);
            sh[k] = WM[k];
            chk_rd(k);
        end
        host_u.xfer(1'b1, 12'h3fc, 32'hff, rdv, err);
        `CHK("unmapped write error", 1'b1, err)
        host_u.xfer(1'b0, 12'h3fc, 32'h0, rdv, err);
        `CHK("unmapped read data", 32'h0, rdv)
        `CHK("outputs", exp_out(), outs)
        $display("test register access done");
        wr(12'h344, 8'h1f);
        // The supply event must be masked for the first crossing.
        sh[0] = 8'h0f;
        wr(AD[0], 8'h0f);
        supply_below_threshold_live <= 1'b1;
        wait_pins();
        chk_rd(0);
        `CHK("irq", 1'b0, irq)
        supply_below_threshold_live <= 1'b0;
        wait_pins();
        sh[0] = 8'h8f;
        wr(AD[0], sh[0]);
        supply_below_threshold_live <= 1'b1;
        flag[0] = 1'b1;
        wait_pins();
        chk_rd(0);
        `CHK("irq", 1'b1, irq)
        wr(12'h348, 8'h01);
        flag[0] = 1'b0;
        chk_rd(0);
        sh[1] = 8'h00;
        wr(AD[1], 8'h00);
        thermal_alarm <= 1'b1;
        wait_pins();
        chk_rd(1);
        thermal_alarm <= 1'b0;
        sh[1] = 8'h80;
        wr(AD[1], 8'h80);
        thermal_alarm <= 1'b1;
        flag[1] = 1'b1;
        wait_pins();
        chk_rd(1);
        `CHK("irq", 1'b1, irq)
        wr(12'h344, 8'h00);
        // The interrupt output is registered and lags the enable write.
        wait_pins();
        `CHK("irq", 1'b0, irq)
        wr(12'h348, 8'h1f);
        flag = 2'b00;
        wr(12'h344, 8'h1c);
        sh[3] = sh[3] | 8'h02;
        sh[5] = sh[5] & 8'h84;
        wr(AD[3], sh[3]);
        wr(AD[5], sh[5]);
        regulator_fault <= 3'b010;
        wait_pins();
        `CHK("irq", 1'b0, irq)
        regulator_fault <= 3'b011;
        wait_pins();
        `CHK("irq", 1'b1, irq)
        host_u.xfer(1'b0, 12'h340, 32'h0, rdv, err);
        `CHK("irq status", 32'h04, rdv)
        host_u.xfer(1'b0, 12'h344, 32'h0, rdv, err);
        `CHK("irq enable", 32'h1c, rdv)
        regulator_power_good <= ~regulator_power_good;
        wait_pins();
        for (int j = 3; j < 10; j += 2) chk_rd(j);
        $display("test events done");
        rst();
        summarize();
    end
endmodule // testbench

bind prc_regs prc_regs_props chk_u (.*);
